// File: rtl/lcrs_core.sv
// Link command reject status and error reporting block with an APB slave.
// Assumes frame decode logic on pclk supplies one-cycle event pulses.
//
// Overview of operation
// [RQ1] Sequence byte: receive count bits 0-2, send count bits 4-6, bits 3,7 zero.
// [RQ2] Reason byte bits 0 through 3 always read zero.
// [RQ3] Reason bit 4 when received count in rejected control field is out of range.
// [RQ4] Reason bit 5 and frame refused on oversize info; never with bit 7.
// [RQ5] Reason bit 6 on forbidden info field, always with bit 7.
// [RQ6] Reason bit 7 on invalid or unimplemented command.
// [RQ7] Link trouble posted after 20 retry, reject or init events combined.
// [RQ8] Trouble accumulator cleared when a sent information frame is confirmed.
// [RQ9] Data-with-command sets error-detail bit 6 together with invalid command.
// [RQ10] Modem interface error when ready signal drops while it should stay up.
// [RQ11] Disconnect command acknowledged, response sent before status returned.
// [RQ12] Twenty consecutive disconnects count as link trouble.
// [RQ13] Dump completion flags detail bits 4,6,7 as rejects, buffer data bad.
// [RQ14] Error-detail bit 0 on checksum failure of last received message.
// [RQ15] Idle timeout after 20 seconds with no flags received.
// [RQ16] Idle timeout takes priority over nonproductive receive timeout.
// [RQ17] Error-detail bit 7 on undefined command in good-checksum frame.
// [RQ18] Meaningless hardware status reports invalid status and resets adapter.
// [RQ19] Error-detail bit 4 on illegal receive count in good-checksum frame.
// [RQ20] Reject bytes and detail bits held until software reads the completion; the code releases them only when software writes one to status bit 0.
//
// Our own choices: the APB interface to the registers and the address map.
`default_nettype none
`include "lcrs_regs.svh"

module lcrs_core #(
  parameter int unsigned IDLE_CYCLES = `LCRS_IDLE_SECONDS * `LCRS_CLK_HZ, // Idle limit
  parameter int unsigned NONPRODUCTIVE_TIMEOUT_CYCLES = `LCRS_NONPRODUCTIVE_TIMEOUT_SECONDS * `LCRS_CLK_HZ  // Nonproductive limit
) (
  input  wire logic        pclk,              // APB clock
  input  wire logic        presetn,           // Async reset, active low
  input  wire logic        psel,              // APB select
  input  wire logic        penable,           // APB enable
  input  wire logic        pwrite,            // APB direction
  input  wire logic [11:0] paddr,             // APB byte address
  input  wire logic [31:0] pwdata,            // APB write data
  input  wire logic [3:0]  pstrb,             // APB byte strobes
  output logic      [31:0] prdata,            // APB read data
  output logic             pready,            // APB ready
  output logic             pslverr,           // APB error
  input  wire logic        frame_good,        // Good-checksum frame ended
  input  wire logic        frame_crc_bad,     // Checksum failed
  input  wire logic        frame_abort,       // Remote aborted frame
  input  wire logic        cmd_invalid,       // Undefined or unimplemented command
  input  wire logic        cmd_data_bad,      // Info field not allowed with command
  input  wire logic        nr_out_of_range,   // Receive count out of range
  input  wire logic        info_too_long,     // Info exceeds supplied buffer
  input  wire logic [7:0]  frame_ctrl,        // Received control field
  input  wire logic [2:0]  recv_count,        // Current receive count
  input  wire logic [2:0]  send_count,        // Current send count
  input  wire logic        write_retry,       // Write retry event
  input  wire logic        reject_once_event, // Reject-once event
  input  wire logic        xid_event,         // Exchange identification event
  input  wire logic        unnumbered_ack_event, // Unnumbered ack event
  input  wire logic        request_init_event,// Request initialization event
  input  wire logic        iframe_confirmed,  // Sent info frame confirmed
  input  wire logic        disc_cmd,          // Set-disconnect-mode command received
  input  wire logic        ack_sent,          // Acknowledgement response transmitted
  input  wire logic        other_frame,       // Any non-disconnect frame received
  input  wire logic        dsr_pin,           // Data-set-ready pin, asynchronous
  input  wire logic        dsr_expected,      // Ready should be asserted
  input  wire logic        flag_pin,          // Flag seen on line, asynchronous
  input  wire logic        hw_status_bad,     // Interrupt status not meaningful
  output logic             frame_refused,     // Frame not accepted
  output logic             send_unnumbered_ack, // Request acknowledgement response
  output logic             adapter_reset,     // Reset command to adapter
  output logic             buffer_bad         // Buffered data discarded for reuse
);
  lcrs_pkg::lcrs_state_s s_reg;
  lcrs_pkg::lcrs_state_s s_next;

  logic        wr_en;
  logic        rd_setup;
  logic        reject;
  logic        trouble_hit;
  logic        dsr_s;
  logic        flag_s;
  logic [4:0]  trouble_inc;
  logic        hold;
  logic [8:0]  st_set;
  logic [8:0]  st_clr;

  assign pready  = 1'b1;
  assign wr_en   = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign pslverr = psel & penable & (paddr > `LCRS_OFF_ID);
  assign prdata  = s_reg.prdata;
  assign dsr_s   = s_reg.dsr_sync[1];
  assign flag_s  = s_reg.flag_sync[1];
  assign hold    = s_reg.status[`LCRS_ST_DONE];
  assign reject  = nr_out_of_range | cmd_invalid | cmd_data_bad | info_too_long;

  assign frame_refused       = info_too_long & frame_good;             // [RQ4]
  assign send_unnumbered_ack = s_reg.ack_pend;                         // [RQ11]
  assign adapter_reset       = s_reg.adapter_reset;                    // [RQ18]
  assign buffer_bad          = s_reg.status[`LCRS_ST_DUMP];            // [RQ13]

  always_comb begin
    s_next = s_reg;
    s_next.adapter_reset = 1'b0;
    s_next.dsr_sync  = {s_reg.dsr_sync[1:0], dsr_pin};
    s_next.flag_sync = {s_reg.flag_sync[0], flag_pin};
    trouble_inc = 5'h00;
    trouble_hit = 1'b0;
    st_set = 9'h000;
    st_clr = 9'h000;

    // Per-frame error capture; held while the completion bit is set, until software writes one to clear it
    if (!hold && (frame_good | frame_crc_bad | frame_abort)) begin // [RQ20]
      s_next.err_detail = 8'h00;
      s_next.err_detail[`LCRS_ED_FCS]   = frame_crc_bad;            // [RQ14]
      s_next.err_detail[`LCRS_ED_ABORT] = frame_abort;
      if (frame_good) begin
        s_next.err_detail[`LCRS_ED_BAD_NR]    = nr_out_of_range;    // [RQ19]
        s_next.err_detail[`LCRS_ED_WRONG_LEN] = info_too_long & ~cmd_invalid & ~cmd_data_bad;
        s_next.err_detail[`LCRS_ED_DATA_CMD]  = cmd_data_bad;       // [RQ9]
        s_next.err_detail[`LCRS_ED_INV_CMD]   = cmd_invalid | cmd_data_bad; // [RQ17] [RQ9]
      end
      st_set[`LCRS_ST_DONE] = 1'b1;
      if (frame_good && reject) begin
        s_next.rej_ctrl = frame_ctrl;                               // [RQ3]
        s_next.rej_seq  = {1'b0, send_count, 1'b0, recv_count};     // [RQ1]
        s_next.rej_reason = {cmd_invalid | cmd_data_bad,            // [RQ6] [RQ5]
                             cmd_data_bad,                          // [RQ5]
                             info_too_long & ~cmd_invalid & ~cmd_data_bad, // [RQ4]
                             nr_out_of_range,                       // [RQ3]
                             4'h0};                                 // [RQ2]
        st_set[`LCRS_ST_REJECT] = 1'b1;
        // Dump completion: bits 4, 6, 7 are reject conditions
        st_set[`LCRS_ST_DUMP] = nr_out_of_range | cmd_invalid | cmd_data_bad; // [RQ13]
      end
    end

    // Trouble accumulator over mixed link events
    trouble_inc = 5'(write_retry) + 5'(reject_once_event) + 5'(xid_event)
                + 5'(unnumbered_ack_event) + 5'(request_init_event)
                + 5'(frame_good & reject);                          // [RQ7]
    if (iframe_confirmed) begin
      s_next.trouble_cnt = 5'h00;                                   // [RQ8]
    end else if (5'(s_reg.trouble_cnt + trouble_inc) >= `LCRS_TROUBLE_LIMIT) begin
      trouble_hit = 1'b1;                                           // [RQ7]
      s_next.trouble_cnt = 5'h00;
    end else begin
      s_next.trouble_cnt = 5'(s_reg.trouble_cnt + trouble_inc);
    end

    // Disconnect: acknowledge, then post status after response is sent
    if (disc_cmd) begin
      s_next.ack_pend = 1'b1;                                       // [RQ11]
    end else if (s_reg.ack_pend && ack_sent) begin
      s_next.ack_pend = 1'b0;
      st_set[`LCRS_ST_DISC] = 1'b1;                                 // [RQ11]
      if (5'(s_reg.disc_cnt + 5'h01) >= `LCRS_TROUBLE_LIMIT) begin
        trouble_hit = 1'b1;                                         // [RQ12]
        s_next.disc_cnt = 5'h00;
      end else begin
        s_next.disc_cnt = 5'(s_reg.disc_cnt + 5'h01);
      end
    end else if (other_frame) begin
      s_next.disc_cnt = 5'h00;                                      // [RQ12]
    end
    if (trouble_hit) begin
      st_set[`LCRS_ST_TROUBLE] = 1'b1;                              // [RQ7] [RQ12]
    end

    if (dsr_expected && !dsr_s && s_reg.dsr_sync[2]) begin
      st_set[`LCRS_ST_MODEM] = 1'b1;                                // [RQ10]
    end

    // Idle and nonproductive timers
    if (!s_reg.ctrl[`LCRS_CTRL_ENABLE] || flag_s) begin
      s_next.idle_cnt = 32'h0;
    end else if (s_reg.idle_cnt < IDLE_CYCLES) begin
      s_next.idle_cnt = s_reg.idle_cnt + 32'h1;
    end
    if (!s_reg.ctrl[`LCRS_CTRL_ENABLE] || frame_good) begin
      s_next.nonproductive_timeout_cnt = 32'h0;
    end else if (s_reg.nonproductive_timeout_cnt < NONPRODUCTIVE_TIMEOUT_CYCLES) begin
      s_next.nonproductive_timeout_cnt = s_reg.nonproductive_timeout_cnt + 32'h1;
    end
    // Expiry only counts while the timers are enabled
    if (s_reg.ctrl[`LCRS_CTRL_ENABLE] && s_reg.idle_cnt + 32'h1 == IDLE_CYCLES
        && !flag_s) begin
      st_set[`LCRS_ST_IDLE] = 1'b1;                                 // [RQ15]
      s_next.nonproductive_timeout_cnt = 32'h0;                                      // [RQ16]
    end else if (s_reg.ctrl[`LCRS_CTRL_ENABLE] && s_reg.nonproductive_timeout_cnt + 32'h1 == NONPRODUCTIVE_TIMEOUT_CYCLES
                 && !frame_good) begin
      st_set[`LCRS_ST_NONPRODUCTIVE_TIMEOUT] = 1'b1;                                 // [RQ16]
    end

    // Invalid hardware status: report and reset the adapter
    unique case (s_reg.mode)
      lcrs_pkg::LCRS_IDLE: begin
        if (hw_status_bad) begin
          st_set[`LCRS_ST_INV_STATUS] = 1'b1;                       // [RQ18]
          s_next.mode = lcrs_pkg::LCRS_HOLD;
        end
      end
      lcrs_pkg::LCRS_HOLD: begin
        s_next.adapter_reset = 1'b1;                                // [RQ18]
        s_next.mode = lcrs_pkg::LCRS_RST;
      end
      lcrs_pkg::LCRS_RST: begin
        s_next.mode = lcrs_pkg::LCRS_IDLE;
      end
      default: s_next.mode = lcrs_pkg::LCRS_IDLE;
    endcase

    // Read data is captured in the setup cycle so it stands through the access cycle
    s_next.prdata = 32'h0;
    if (rd_setup) begin
      unique case (paddr)
        `LCRS_OFF_CTRL:       s_next.prdata = {30'h0, s_reg.ctrl};
        `LCRS_OFF_STATUS:     s_next.prdata = {23'h0, s_reg.status};
        `LCRS_OFF_ERR_DETAIL: s_next.prdata = {24'h0, s_reg.err_detail};
        `LCRS_OFF_COMMAND_REJECT_FRAME:       s_next.prdata = {8'h0, s_reg.rej_reason, s_reg.rej_seq,
                                               s_reg.rej_ctrl};
        `LCRS_OFF_TROUBLE:    s_next.prdata = {19'h0, s_reg.disc_cnt, 3'h0, s_reg.trouble_cnt};
        `LCRS_OFF_ID:         s_next.prdata = `LCRS_ID_VALUE;       // Arbitrary value
        default:              s_next.prdata = 32'h0;
      endcase
    end
    if (wr_en && paddr == `LCRS_OFF_CTRL && pstrb[0]) begin
      s_next.ctrl = pwdata[1:0];
    end
    // Write-one-to-clear; an event in the same cycle wins over the clear
    if (wr_en && paddr == `LCRS_OFF_STATUS) begin
      st_clr = pwdata[8:0];
    end
    s_next.status = (s_reg.status & ~st_clr) | st_set;              // [RQ20]
  end

  // One register holds every field of state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule
`default_nettype wire

// File: include/lcrs_regs.svh
// Register offsets, field positions, identity value and timing counts for the
// link command reject status block. Assumes an APB slave with 32-bit data.
`ifndef LCRS_REGS_SVH
`define LCRS_REGS_SVH

`define LCRS_OFF_CTRL       12'h000
`define LCRS_OFF_STATUS     12'h004
`define LCRS_OFF_ERR_DETAIL 12'h008
`define LCRS_OFF_COMMAND_REJECT_FRAME       12'h00c
`define LCRS_OFF_TROUBLE    12'h010
`define LCRS_OFF_ID         12'h014

// Error-detail bits
`define LCRS_ED_FCS         0
`define LCRS_ED_ABORT       1
`define LCRS_ED_BAD_NR      4
`define LCRS_ED_WRONG_LEN   5
`define LCRS_ED_DATA_CMD    6
`define LCRS_ED_INV_CMD     7

// Status bits
`define LCRS_ST_DONE        0
`define LCRS_ST_DUMP        1
`define LCRS_ST_TROUBLE     2
`define LCRS_ST_MODEM       3
`define LCRS_ST_DISC        4
`define LCRS_ST_IDLE        5
`define LCRS_ST_NONPRODUCTIVE_TIMEOUT        6
`define LCRS_ST_INV_STATUS  7
`define LCRS_ST_REJECT      8

// Control bits
`define LCRS_CTRL_ENABLE    0
`define LCRS_CTRL_SWITCHED  1

`define LCRS_TROUBLE_LIMIT  5'h14
`define LCRS_IDLE_SECONDS   20
`define LCRS_NONPRODUCTIVE_TIMEOUT_SECONDS   20
`define LCRS_CLK_HZ         32'h0773_5940
`define LCRS_ID_VALUE       32'h0000_5a01

`endif

// File: include/lcrs_pkg.sv
// Types for the link command reject status block.
// Assumes lcrs_regs.svh supplies all numeric constants.
`default_nettype none
package lcrs_pkg;
  typedef enum logic [1:0] {
    LCRS_IDLE = 2'b00,
    LCRS_HOLD = 2'b01,
    LCRS_RST  = 2'b11
  } lcrs_mode_e;

  typedef struct packed {
    lcrs_mode_e  mode;
    logic [7:0]  err_detail;
    logic [7:0]  rej_ctrl;
    logic [7:0]  rej_seq;
    logic [7:0]  rej_reason;
    logic [8:0]  status;
    logic [4:0]  trouble_cnt;
    logic [4:0]  disc_cnt;
    logic [31:0] idle_cnt;
    logic [31:0] nonproductive_timeout_cnt;
    logic [1:0]  ctrl;
    logic [2:0]  dsr_sync;
    logic [1:0]  flag_sync;
    logic        adapter_reset;
    logic        ack_pend;
    logic [31:0] prdata;
  } lcrs_state_s;
endpackage
`default_nettype wire

// File: testbench/lcrs_core_properties.sv
// Port checker for lcrs_core.
// Assumes it is bound into lcrs_core; one pclk domain.
`default_nettype none
module lcrs_properties (
  input wire logic pclk,                // Clock
  input wire logic presetn,             // Reset
  input wire logic psel,                // Select
  input wire logic penable,             // Enable
  input wire logic pwrite,              // Direction
  input wire logic frame_good,          // Frame end
  input wire logic info_too_long,       // Oversize
  input wire logic frame_refused,       // Refusal
  input wire logic disc_cmd,            // Disconnect
  input wire logic ack_sent,            // Ack out
  input wire logic send_unnumbered_ack, // Ack request
  input wire logic hw_status_bad,       // Bad status
  input wire logic adapter_reset,       // Reset cmd
  input wire logic buffer_bad           // Dump flag
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence rst_issue_s;
    ##2 adapter_reset;
  endsequence
  refuse_long_a: assert property (frame_good && info_too_long |-> frame_refused)
    else $error("oversize frame not refused");
  refuse_only_a: assert property (frame_refused |-> frame_good && info_too_long)
    else $error("frame refused without cause");
  ack_request_a: assert property (disc_cmd |=> send_unnumbered_ack)
    else $error("no ack request after disconnect");
  ack_hold_a: assert property (send_unnumbered_ack && !ack_sent |=> send_unnumbered_ack)
    else $error("ack request dropped early");
  ack_drop_a: assert property (ack_sent && !disc_cmd |=> !send_unnumbered_ack)
    else $error("ack request kept after send");
  ack_cause_a: assert property ($rose(send_unnumbered_ack) |-> $past(disc_cmd))
    else $error("ack request without disconnect");
  reset_issue_a: assert property (hw_status_bad |-> rst_issue_s)
    else $error("no adapter reset after bad status");
  reset_cause_a: assert property (adapter_reset |-> $past(hw_status_bad, 2))
    else $error("adapter reset without cause");
  dump_hold_a: assert property (buffer_bad && !(psel && penable && pwrite) |=> buffer_bad)
    else $error("dump flag lost before clear");
endmodule
`default_nettype wire

// File: testbench/lcrs_remote_station.sv
// Remote primary station: pulses received-frame events, sends acks.
// Assumes the bench calls its tasks right after a rising pclk edge.
`default_nettype none
module lcrs_remote_station (
  input  wire logic        pclk,                // Clock
  input  wire logic        send_unnumbered_ack, // Ack requested
  output logic      [14:0] ev,                  // Event pulses
  output logic      [7:0]  frame_ctrl,          // Control field
  output logic      [2:0]  recv_count,          // Receive count
  output logic      [2:0]  send_count,          // Send count
  output logic             ack_sent,            // Ack transmitted
  output logic             dsr_pin,             // Ready line
  output logic             flag_pin             // Flag seen
);
  timeunit 1ns;
  timeprecision 1ps;
  int ack_wait = 1;
  initial begin
    ev = '0;
    frame_ctrl = '0;
    recv_count = '0;
    send_count = '0;
    ack_sent = 1'b0;
    dsr_pin = 1'b1;
    flag_pin = 1'b1;
  end
  // Fields go to the inverse once the frame has ended
  task automatic pulse(input logic [14:0] m, input logic [7:0] c, input logic [2:0] nr, ns);
    ev <= m;
    frame_ctrl <= c;
    recv_count <= nr;
    send_count <= ns;
    @(posedge pclk);
    ev <= '0;
    frame_ctrl <= ~c;
    recv_count <= ~nr;
    send_count <= ~ns;
    @(posedge pclk);
  endtask
  // Line levels change right after a rising edge
  task automatic set_lines(input logic flag, input logic dsr);
    flag_pin <= flag;
    dsr_pin <= dsr;
  endtask
  always begin
    @(posedge pclk iff send_unnumbered_ack);
    repeat (ack_wait) @(posedge pclk);
    ack_sent <= 1'b1;
    @(posedge pclk);
    ack_sent <= 1'b0;
    @(posedge pclk);
  end
endmodule
`default_nettype wire

// File: testbench/tb_lcrs_core.sv
// Self-checking bench for lcrs_core with a remote station model.
// Assumes register offsets from lcrs_regs.svh and short timer limits.
`default_nettype none
`include "lcrs_regs.svh"
module tb_lcrs_core;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TMR = 40;
  logic        pclk, presetn, psel, penable, pwrite, dsr_expected, hw_status_bad;
  logic        pready, pslverr, se, ack_sent, dsr_pin, flag_pin, send_unnumbered_ack, bb;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [14:0] ev;
  logic [7:0]  frame_ctrl;
  logic [2:0]  recv_count, send_count;
  int          fails = 0;
  int          total_checks = 0;
  lcrs_core #(.IDLE_CYCLES(TMR), .NONPRODUCTIVE_TIMEOUT_CYCLES(TMR)) lcrs_core_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .frame_good(ev[0]), .frame_crc_bad(ev[1]), .frame_abort(ev[2]),
    .cmd_invalid(ev[3]), .cmd_data_bad(ev[4]), .nr_out_of_range(ev[5]),
    .info_too_long(ev[6]), .frame_ctrl(frame_ctrl), .recv_count(recv_count),
    .send_count(send_count), .write_retry(ev[7]), .reject_once_event(ev[8]),
    .xid_event(ev[9]), .unnumbered_ack_event(ev[10]), .request_init_event(ev[11]),
    .iframe_confirmed(ev[12]), .disc_cmd(ev[13]), .ack_sent(ack_sent),
    .other_frame(ev[14]), .dsr_pin(dsr_pin), .dsr_expected(dsr_expected),
    .flag_pin(flag_pin), .hw_status_bad(hw_status_bad), .frame_refused(),
    .send_unnumbered_ack(send_unnumbered_ack), .adapter_reset(), .buffer_bad(bb));
  lcrs_remote_station lcrs_remote_station_inst (
    .pclk(pclk), .send_unnumbered_ack(send_unnumbered_ack), .ev(ev),
    .frame_ctrl(frame_ctrl), .recv_count(recv_count), .send_count(send_count),
    .ack_sent(ack_sent), .dsr_pin(dsr_pin), .flag_pin(flag_pin));
  task automatic final_report;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Read data and error flag are taken at the edge that completes the access
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    se = pslverr;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic clr;
    apb(1'b1, `LCRS_OFF_STATUS, 32'h0000_01ff);
  endtask
  task automatic stat(input int b, input logic e);
    apb(1'b0, `LCRS_OFF_STATUS, '0);
    check("status bit", {31'h0, e}, {31'h0, rd[b]});
  endtask
  task automatic t_regs;
    apb(1'b0, `LCRS_OFF_ERR_DETAIL, '0);
    check("detail reset", 32'h0, rd);
    apb(1'b0, 12'h018, '0);
    check("unmapped error", 32'h1, {31'h0, se});
  endtask
  task automatic t_reject;
    logic [14:0] q[4] = '{15'h0009, 15'h0019, 15'h0021, 15'h0041};
    logic [7:0]  r[4] = '{8'h80, 8'hc0, 8'h10, 8'h20};
    for (int i = 0; i < 4; i++) begin
      clr();
      lcrs_remote_station_inst.pulse(q[i], 8'h31 + 8'(i), 3'(i), 3'(7 - i));
      apb(1'b0, `LCRS_OFF_COMMAND_REJECT_FRAME, '0);
      check("reject word", {8'h0, r[i], 1'b0, 3'(7 - i), 1'b0, 3'(i), 8'h31 + 8'(i)}, rd);
      check("dump flag", {31'h0, i < 3}, {31'h0, bb});
      apb(1'b0, `LCRS_OFF_ERR_DETAIL, '0);
      check("detail high", {28'h0, r[i][7:4]}, {28'h0, rd[7:4]});
    end
    clr();
    lcrs_remote_station_inst.pulse(15'h0002, 8'h00, 3'h0, 3'h0);
    apb(1'b0, `LCRS_OFF_ERR_DETAIL, '0);
    check("checksum bit", 32'h1, {31'h0, rd[0]});
    lcrs_remote_station_inst.pulse(15'h0009, 8'h00, 3'h0, 3'h0);
    apb(1'b0, `LCRS_OFF_ERR_DETAIL, '0);
    check("detail held", 32'h1, rd);
  endtask
  task automatic t_trouble;
    lcrs_remote_station_inst.pulse(15'h1000, 8'h0, 3'h0, 3'h0);
    for (int k = 0; k < 2; k++) begin
      clr();
      for (int i = 0; i < 19; i++) begin
        lcrs_remote_station_inst.pulse(15'h0080 << (i % 5), 8'h0, 3'h0, 3'h0);
      end
      stat(2, 1'b0);
      if (k == 0) lcrs_remote_station_inst.pulse(15'h1000, 8'h0, 3'h0, 3'h0);
    end
    lcrs_remote_station_inst.pulse(15'h0100, 8'h0, 3'h0, 3'h0);
    stat(2, 1'b1);
    clr();
    lcrs_remote_station_inst.pulse(15'h0100, 8'h0, 3'h0, 3'h0);
    stat(2, 1'b0);
  endtask
  task automatic t_disc;
    lcrs_remote_station_inst.pulse(15'h1000, 8'h0, 3'h0, 3'h0);
    clr();
    for (int i = 1; i <= 20; i++) begin
      lcrs_remote_station_inst.ack_wait = (i % 2) ? 1 : 6;
      lcrs_remote_station_inst.pulse(15'h2000, 8'h0, 3'h0, 3'h0);
      repeat (10) @(posedge pclk);
      if (i == 19) stat(2, 1'b0);
    end
    stat(2, 1'b1);
    stat(4, 1'b1);
  endtask
  task automatic t_misc;
    clr();
    lcrs_remote_station_inst.set_lines(1'b0, 1'b1);
    repeat (4) @(posedge pclk);
    apb(1'b1, `LCRS_OFF_CTRL, 32'h3);
    repeat (TMR + 10) @(posedge pclk);
    stat(5, 1'b1);
    stat(6, 1'b0);
    dsr_expected <= 1'b1;
    repeat (6) @(posedge pclk);
    stat(3, 1'b0);
    lcrs_remote_station_inst.set_lines(1'b0, 1'b0);
    repeat (6) @(posedge pclk);
    stat(3, 1'b1);
    hw_status_bad <= 1'b1;
    @(posedge pclk);
    hw_status_bad <= 1'b0;
    repeat (4) @(posedge pclk);
    stat(7, 1'b1);
  endtask
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    $display("CHECK FAILED watchdog expected end seen hang");
    final_report();
  end
  initial begin
    {presetn, psel, penable, pwrite, dsr_expected, hw_status_bad} = '0;
    paddr = '0;
    pwdata = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_reject();
    t_trouble();
    t_disc();
    t_misc();
    final_report();
  end
endmodule
bind lcrs_core lcrs_properties lcrs_properties_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .frame_good(frame_good), .info_too_long(info_too_long), .frame_refused(frame_refused),
  .disc_cmd(disc_cmd), .ack_sent(ack_sent), .send_unnumbered_ack(send_unnumbered_ack),
  .hw_status_bad(hw_status_bad), .adapter_reset(adapter_reset), .buffer_bad(buffer_bad));
`default_nettype wire
